// *** rtl/cpust_core_state.v ***
// CPU core state register file: dedicated registers, flags, mask and mode decode.
//
// Contract
// - Program counter is 32 bits and holds the next instruction address.
// - A 32-bit program status word stores condition codes and status.
// - Status word holds condition flags, system flags and interrupt level mask.
// - Vector table base register holds the exception table start address.
// - Return address register holds the resume address after a subroutine.
// - Separate system and user stack pointers; stack flag picks R15 view.
// - Multiply/divide results live in high and low 32-bit registers.
// - User interrupt enable flag gates acceptance of interrupt requests.
// - Negative flag follows the result sign bit.
// - Zero flag is set exactly when the result is zero.
// - Overflow flag shows signed two's-complement overflow.
// - Carry flag shows carry out of or borrow into the top bit.
// - Trace flag enables the step trace trap.
// - Level mask is five bits, levels 0 to 31, zero is highest.
// - Request accepted only when its level is numerically below the mask.
// - Sixteen general registers; R13 accumulator, R14 frame, R15 stack.
// - After reset R0 to R14 undefined, R15 reads zero.
// - Strap pins decode external 8/16-bit, inhibited, internal, unused.
// - Bus select bits decode single-chip, internal ROM, external ROM, inhibited.
// - External area only reachable in internal-ROM external-bus mode.
`timescale 1ns/100ps
`default_nettype none
`include "cpust_defines.vh"

module cpust_core_state
(
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [4:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  input  wire        pc_load,
  input  wire [31:0] pc_next,
  input  wire        alu_valid,
  input  wire [1:0]  alu_op,
  input  wire [31:0] alu_a,
  input  wire [31:0] alu_b,
  input  wire        md_valid,
  input  wire [31:0] md_high,
  input  wire [31:0] md_low,
  input  wire        irq_req,
  input  wire [4:0]  irq_level,
  input  wire        mode_strap_pin_0,
  input  wire        mode_strap_pin_1,
  input  wire        mode_strap_pin_2,
  input  wire        ext_access_req,
  output reg  [31:0] program_counter,
  output wire [31:0] program_status_word,
  output reg  [31:0] vector_table_base,
  output reg  [31:0] return_address_holder,
  output reg  [31:0] stack_pointer_view,
  output reg  [31:0] product_high_word,
  output reg  [31:0] product_low_word,
  output wire        irq_accept,
  output wire        trace_enable,
  output wire        reset_vector_internal,
  output wire        ext_bus_16bit,
  output wire        strap_mode_invalid,
  output wire [1:0]  bus_mode_sel,
  output wire        bus_mode_invalid,
  output wire        ext_access_grant
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  reg  [31:0] system_stack_pointer;
  reg  [31:0] user_stack_pointer;
  reg  [5:0]  condition_flags_field;
  reg         system_flags_field;
  reg  [4:0]  interrupt_level_mask;
  reg  [1:0]  bus_mode_register;
  reg  [2:0]  strap_latched;
  reg         rd_pending;
  reg  [4:0]  rd_addr_q;
  reg  [31:0] next_rdata;
  reg  [31:0] rdata_q;
  reg  [3:0]  next_flags;
  reg  [32:0] alu_wide;
  reg  [31:0] alu_res;
  reg  [31:0] alu_result;
  wire [31:0] gpr_rdata;
  wire        wr_gpr;
  wire        wr_r15;
  wire        stack_sel;

  wire bus_mode_select_high = bus_mode_register[1];
  wire bus_mode_select_low  = bus_mode_register[0];

  // ==========================================================================
  // Status word assembly
  // ==========================================================================
  // Condition flags in the low byte, trace flag above, level mask at bit 16.
  assign program_status_word = {11'h000, interrupt_level_mask, 7'h00,
                                system_flags_field, 2'h0,
                                condition_flags_field};
  assign stack_sel = condition_flags_field[`CPUST_PSW_S];
  assign trace_enable = system_flags_field;

  // ==========================================================================
  // Interrupt acceptance
  // ==========================================================================
  // Numerically lower level is higher priority; equal level is refused.
  assign irq_accept = irq_req & condition_flags_field[`CPUST_PSW_I] &
                      (irq_level < interrupt_level_mask);

  // ==========================================================================
  // Strap pins: synchronise, then capture only while reset is applied
  // ==========================================================================
  // These flops have no reset: they must follow the pins while rst is high,
  // and the latch then freezes the mode from release on.
  reg [2:0] strap_raw_q;
  reg [2:0] strap_raw_q2;
  always @(posedge sys_clk)
  begin
    strap_raw_q  <= {mode_strap_pin_2, mode_strap_pin_1, mode_strap_pin_0};
    strap_raw_q2 <= strap_raw_q;
    if (rst)
    begin
      strap_latched <= strap_raw_q2;
    end
  end

  // Decode the frozen strap pattern.
  assign reset_vector_internal = (strap_latched == `CPUST_STRAP_INT);
  assign ext_bus_16bit         = (strap_latched == `CPUST_STRAP_EXT16);
  assign strap_mode_invalid    = (strap_latched == `CPUST_STRAP_INHIB) |
                                 strap_latched[2];

  // ==========================================================================
  // Bus mode decode
  // ==========================================================================
  assign bus_mode_sel     = {bus_mode_select_high, bus_mode_select_low};
  assign bus_mode_invalid = (bus_mode_sel == `CPUST_BUS_INHIB);
  // External area is closed until software picks internal ROM with external bus.
  assign ext_access_grant = ext_access_req &
                            (bus_mode_sel == `CPUST_BUS_INTROM_EXT);

  // ==========================================================================
  // Condition flag computation
  // ==========================================================================
  always @*
  begin
    alu_wide   = 33'h000000000;
    alu_res    = 32'h00000000;
    next_flags = condition_flags_field[3:0];
    case (alu_op)
      `CPUST_OP_ADD:
      begin
        alu_wide = {1'b0, alu_a} + {1'b0, alu_b};
        alu_res  = alu_wide[31:0];
        next_flags[`CPUST_PSW_V] = (alu_a[31] == alu_b[31]) &
                                   (alu_res[31] != alu_a[31]);
        next_flags[`CPUST_PSW_C] = alu_wide[32];
      end
      `CPUST_OP_SUB:
      begin
        alu_wide = {1'b0, alu_a} - {1'b0, alu_b};
        alu_res  = alu_wide[31:0];
        next_flags[`CPUST_PSW_V] = (alu_a[31] != alu_b[31]) &
                                   (alu_res[31] != alu_a[31]);
        next_flags[`CPUST_PSW_C] = alu_wide[32];
      end
      default:
      begin
        alu_res = alu_a;
      end
    endcase
    next_flags[`CPUST_PSW_N] = alu_res[31];
    next_flags[`CPUST_PSW_Z] = (alu_res == 32'h00000000);
  end

  // ==========================================================================
  // Dedicated registers
  // ==========================================================================
  // Hardware updates (fetch, ALU, multiplier) win over a software write in the
  // same cycle, so no event is lost.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      program_counter       <= `CPUST_RST_PC;
      condition_flags_field <= 6'h00;
      system_flags_field    <= 1'b0;
      interrupt_level_mask  <= 5'h1f;
      vector_table_base     <= `CPUST_RST_TBASE;
      return_address_holder <= `CPUST_RST_WORD;
      system_stack_pointer  <= `CPUST_RST_SP;
      user_stack_pointer    <= `CPUST_RST_SP;
      product_high_word     <= `CPUST_RST_WORD;
      product_low_word      <= `CPUST_RST_WORD;
      bus_mode_register     <= `CPUST_RST_BUSMODE;
      alu_result            <= `CPUST_RST_WORD;
    end
    else
    begin
      if (reg_wr)
      begin
        if (reg_addr == `CPUST_OFS_PC)
        begin
          program_counter <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_PSW)
        begin
          condition_flags_field <= reg_wdata[5:0];
          system_flags_field    <= reg_wdata[`CPUST_PSW_T];
          interrupt_level_mask  <= reg_wdata[`CPUST_PSW_ILM_HI:`CPUST_PSW_ILM_LO];
        end
        else if (reg_addr == `CPUST_OFS_TBASE)
        begin
          vector_table_base <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_RET)
        begin
          return_address_holder <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_SSP)
        begin
          system_stack_pointer <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_USP)
        begin
          user_stack_pointer <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_PRODH)
        begin
          product_high_word <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_PRODL)
        begin
          product_low_word <= reg_wdata;
        end
        else if (reg_addr == `CPUST_OFS_BUSMODE)
        begin
          bus_mode_register <= reg_wdata[1:0];
        end
        else if (wr_r15)
        begin
          // R15 writes land in whichever stack pointer is selected.
          if (stack_sel)
          begin
            user_stack_pointer <= reg_wdata;
          end
          else
          begin
            system_stack_pointer <= reg_wdata;
          end
        end
      end
      if (pc_load)
      begin
        program_counter <= pc_next;
      end
      if (alu_valid)
      begin
        condition_flags_field[3:0] <= next_flags;
        alu_result <= alu_res;
      end
      if (md_valid)
      begin
        product_high_word <= md_high;
        product_low_word  <= md_low;
      end
    end
  end

  // ==========================================================================
  // General registers R0 to R14
  // ==========================================================================
  assign wr_gpr = reg_wr & (reg_addr[4] == 1'b1) & (reg_addr[3:0] != 4'hf);
  assign wr_r15 = (reg_addr == (`CPUST_OFS_GPR_BASE | 5'h0f));

  // R13 works as accumulator and R14 as frame_base_pointer by software convention.
  cpust_gpr_mem u_gpr
  (
    .sys_clk (sys_clk),
    .wr_en   (wr_gpr),
    .wr_addr (reg_addr[3:0]),
    .wr_data (reg_wdata),
    .rd_addr (reg_addr[3:0]),
    .rd_data (gpr_rdata)
  );

  // Selected stack pointer presented as R15; both are zero after reset.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stack_pointer_view <= `CPUST_RST_SP;
    end
    else
    begin
      stack_pointer_view <= stack_sel ? user_stack_pointer
                                      : system_stack_pointer;
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  // Address captured with the strobe; data is assembled in the strobe cycle and registered, so the
  // memory's registered output lines up with the dedicated registers.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_pending <= 1'b0;
      rd_addr_q  <= 5'h00;
      rdata_q    <= 32'h00000000;
    end
    else
    begin
      rd_pending <= reg_rd;
      if (reg_rd)
      begin
        rd_addr_q <= reg_addr;
      end
      rdata_q <= next_rdata;
    end
  end

  // Read data is formed from the strobe cycle's address, registered for the next.
  always @*
  begin
    next_rdata = 32'h00000000;
    if (!reg_rd)
    begin
      next_rdata = 32'h00000000;
    end
    else if (reg_addr == `CPUST_OFS_PC)
    begin
      next_rdata = program_counter;
    end
    else if (reg_addr == `CPUST_OFS_PSW)
    begin
      next_rdata = program_status_word;
    end
    else if (reg_addr == `CPUST_OFS_TBASE)
    begin
      next_rdata = vector_table_base;
    end
    else if (reg_addr == `CPUST_OFS_RET)
    begin
      next_rdata = return_address_holder;
    end
    else if (reg_addr == `CPUST_OFS_SSP)
    begin
      next_rdata = system_stack_pointer;
    end
    else if (reg_addr == `CPUST_OFS_USP)
    begin
      next_rdata = user_stack_pointer;
    end
    else if (reg_addr == `CPUST_OFS_PRODH)
    begin
      next_rdata = product_high_word;
    end
    else if (reg_addr == `CPUST_OFS_PRODL)
    begin
      next_rdata = product_low_word;
    end
    else if (reg_addr == `CPUST_OFS_BUSMODE)
    begin
      next_rdata = {30'h00000000, bus_mode_register};
    end
    else if (reg_addr == `CPUST_OFS_STATUS)
    begin
      next_rdata = {26'h0000000, strap_mode_invalid, bus_mode_invalid,
                    strap_latched, 1'b0};
    end
    else if (reg_addr == `CPUST_OFS_ALU)
    begin
      next_rdata = alu_result;
    end
    else if (wr_r15)
    begin
      next_rdata = stack_sel ? user_stack_pointer : system_stack_pointer;
    end
  end

  // General register reads: the memory output is valid the cycle after the
  // strobe, so it replaces the registered word for R0 to R14.
  wire gpr_rd_hit = rd_pending & rd_addr_q[4] & (rd_addr_q[3:0] != 4'hf);
  assign reg_rdata = gpr_rd_hit ? gpr_rdata : rdata_q;

endmodule

`default_nettype wire

// *** rtl/cpust_gpr_mem.v ***
// Sixteen-word general register memory with registered read data.
`timescale 1ns/100ps
`default_nettype none

module cpust_gpr_mem
(
  input  wire        sys_clk,
  input  wire        wr_en,
  input  wire [3:0]  wr_addr,
  input  wire [31:0] wr_data,
  input  wire [3:0]  rd_addr,
  output reg  [31:0] rd_data
);

  reg [31:0] mem [0:15];

  // ==========================================================================
  // Storage
  // ==========================================================================
  // No reset: the general registers come up undefined, and only the stack
  // pointer slot is overlaid with a defined value by the owner.
  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// *** shared/cpust_defines.vh ***
// Offsets, field positions, reset values and codes of the CPU state register file.
`ifndef CPUST_DEFINES_VH
`define CPUST_DEFINES_VH

// ==========================================================================
// Register offsets on the plain register port.
// ==========================================================================
`define CPUST_ADDR_W           5
`define CPUST_OFS_PC           5'h00
`define CPUST_OFS_PSW          5'h01
`define CPUST_OFS_TBASE        5'h02
`define CPUST_OFS_RET          5'h03
`define CPUST_OFS_SSP          5'h04
`define CPUST_OFS_USP          5'h05
`define CPUST_OFS_PRODH        5'h06
`define CPUST_OFS_PRODL        5'h07
`define CPUST_OFS_BUSMODE      5'h08
`define CPUST_OFS_STATUS       5'h09
`define CPUST_OFS_ALU          5'h0a
`define CPUST_OFS_GPR_BASE     5'h10

// ==========================================================================
// Program status word field positions.
// ==========================================================================
`define CPUST_PSW_C            0
`define CPUST_PSW_V            1
`define CPUST_PSW_Z            2
`define CPUST_PSW_N            3
`define CPUST_PSW_I            4
`define CPUST_PSW_S            5
`define CPUST_PSW_T            8
`define CPUST_PSW_ILM_LO       16
`define CPUST_PSW_ILM_HI       20
`define CPUST_PSW_CCR_MASK     32'h0000003f
`define CPUST_PSW_SCR_MASK     32'h00000100
`define CPUST_PSW_ILM_MASK     32'h001f0000
`define CPUST_PSW_WR_MASK      32'h001f013f

// ==========================================================================
// Reset values.
// ==========================================================================
`define CPUST_RST_PC           32'h00000000
`define CPUST_RST_PSW          32'h001f0000
`define CPUST_RST_TBASE        32'h000ffc00
`define CPUST_RST_SP           32'h00000000
`define CPUST_RST_WORD         32'h00000000
`define CPUST_RST_BUSMODE      2'h0

// ==========================================================================
// Mode codes.
// ==========================================================================
`define CPUST_STRAP_EXT8       3'h0
`define CPUST_STRAP_EXT16      3'h1
`define CPUST_STRAP_INHIB      3'h2
`define CPUST_STRAP_INT        3'h3
`define CPUST_BUS_SINGLE       2'h0
`define CPUST_BUS_INTROM_EXT   2'h1
`define CPUST_BUS_EXTROM_EXT   2'h2
`define CPUST_BUS_INHIB        2'h3

// ALU operation codes used to update the condition flags.
`define CPUST_OP_ADD           2'h0
`define CPUST_OP_SUB           2'h1
`define CPUST_OP_LOGIC         2'h2

`endif

// *** sim/cpust_assertions.sv ***
// Concurrent checks on the ports of the CPU state register file.
`timescale 1ns/100ps
`default_nettype none
`include "cpust_defines.vh"

module cpust_assertions
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        pc_load,
  input wire logic [31:0] pc_next,
  input wire logic        alu_valid,
  input wire logic [1:0]  alu_op,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_level,
  input wire logic        ext_access_req,
  input wire logic [31:0] program_counter,
  input wire logic [31:0] program_status_word,
  input wire logic        irq_accept,
  input wire logic        trace_enable,
  input wire logic        reset_vector_internal,
  input wire logic [1:0]  bus_mode_sel,
  input wire logic        bus_mode_invalid,
  input wire logic        ext_access_grant
);
  // ==========
  // Reference arithmetic
  // ==========
  // The add is modelled here so a flag slip cannot hide behind the design's own adder.
  logic [32:0] sum;
  logic        add_go;
  logic        ref_n;
  logic        ref_z;
  logic        ref_v;
  logic        ref_c;
  logic [31:0] psw;
  assign sum    = {1'b0, alu_a} + {1'b0, alu_b};
  assign add_go = alu_valid && (alu_op == `CPUST_OP_ADD);
  assign ref_n  = sum[31];
  assign ref_z  = (sum[31:0] == 32'h0);
  assign ref_v  = (alu_a[31] == alu_b[31]) && (sum[31] != alu_a[31]);
  assign ref_c  = sum[32];
  assign psw    = program_status_word;

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========
  // Properties
  // ==========
  a_pc_load: assert property (pc_load |=> program_counter == $past(pc_next))
    else $error("program counter missed a load");
  a_sign_flag: assert property (add_go |=> psw[`CPUST_PSW_N] == $past(ref_n))
    else $error("negative flag wrong after add");
  a_zero_flag: assert property (add_go |=> psw[`CPUST_PSW_Z] == $past(ref_z))
    else $error("zero flag wrong after add");
  a_ovf_flag: assert property (add_go |=> psw[`CPUST_PSW_V] == $past(ref_v))
    else $error("overflow flag wrong after add");
  a_carry_flag: assert property (add_go |=> psw[`CPUST_PSW_C] == $past(ref_c))
    else $error("carry flag wrong after add");
  a_irq_gate: assert property (irq_accept == (irq_req && psw[`CPUST_PSW_I]
    && irq_level < psw[`CPUST_PSW_ILM_HI:`CPUST_PSW_ILM_LO])) else $error("bad irq accept");
  a_trace_flag: assert property (trace_enable == psw[`CPUST_PSW_T])
    else $error("trace enable differs from its flag");
  a_ext_grant: assert property (ext_access_grant ==
    (ext_access_req && bus_mode_sel == `CPUST_BUS_INTROM_EXT)) else $error("bad ext grant");
  a_bus_inhib: assert property (bus_mode_invalid == (bus_mode_sel == `CPUST_BUS_INHIB))
    else $error("bus mode inhibit flag wrong");
  a_strap_frozen: assert property (!$past(rst) |-> $stable(reset_vector_internal))
    else $error("strap decode moved after reset");

  // Main scenarios worth seeing at least once.
  c_irq_taken: cover property (irq_accept);
  c_overflow: cover property (add_go ##1 psw[`CPUST_PSW_V]);
  c_grant: cover property (ext_access_grant);
endmodule
`default_nettype wire

// *** sim/cpust_core_state_tb.sv ***
// Self-checking bench for the CPU state register file.
`timescale 1ns/100ps
`default_nettype none
`include "cpust_defines.vh"

bind cpust_core_state cpust_assertions i_chk
(
  .sys_clk(sys_clk), .rst(rst), .pc_load(pc_load), .pc_next(pc_next),
  .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
  .irq_req(irq_req), .irq_level(irq_level), .ext_access_req(ext_access_req),
  .program_counter(program_counter), .program_status_word(program_status_word),
  .irq_accept(irq_accept), .trace_enable(trace_enable),
  .reset_vector_internal(reset_vector_internal), .bus_mode_sel(bus_mode_sel),
  .bus_mode_invalid(bus_mode_invalid), .ext_access_grant(ext_access_grant)
);

module cpust_core_state_tb;
  // ==========
  // Signals and case tables
  // ==========
  logic        sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pc_load = 1'b0;
  logic        alu_valid = 1'b0, md_valid = 1'b0, ext_req = 1'b0, raise = 1'b0;
  logic [1:0]  alu_op = 2'h0;
  logic [2:0]  strap = 3'h0;
  logic [4:0]  addr = 5'h0, level = 5'h0, irq_level;
  logic [31:0] wdata = 32'h0, pc_next = 32'h0, alu_a = 32'h0, alu_b = 32'h0, tbase, ret;
  logic [31:0] md_high = 32'h0, md_low = 32'h0, rdata, pc, psw, sp_view, prod_hi, prod_lo;
  logic        irq_req, pin0, pin1, pin2, irq_accept, trace_en, vec_int, bus16, strap_bad;
  logic        bus_bad, grant;
  logic [1:0]  bus_sel;
  int          bad_count = 0, compares = 0;
  logic [4:0]  rv_ofs [11] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                               5'h1f, 5'h0b, 5'h09};
  logic [31:0] rv_val [11] = '{1: 32'h001f_0000, 2: 32'h000f_fc00, 10: 32'h6, default: 32'h0};
  logic [31:0] iq_psw [8] = '{4: 32'h0005_0000, 5: 32'h001f_0010, 6: 32'h001f_0010,
                              7: 32'h0000_0010, default: 32'h0005_0010};
  logic [4:0]  iq_lvl [8] = '{5'h04, 5'h05, 5'h06, 5'h00, 5'h04, 5'h1e, 5'h1f, 5'h00};
  logic [7:0]  iq_exp = 8'h29;

  always #10 sys_clk = ~sys_clk;

  cpust_partner i_partner
  (
    .sys_clk(sys_clk), .strap_code(strap), .raise(raise), .level(level), .irq_req(irq_req),
    .irq_level(irq_level), .mode_strap_pin_0(pin0), .mode_strap_pin_1(pin1),
    .mode_strap_pin_2(pin2)
  );

  cpust_core_state i_dut
  (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .pc_load(pc_load), .pc_next(pc_next),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .md_valid(md_valid), .md_high(md_high), .md_low(md_low), .irq_req(irq_req),
    .irq_level(irq_level), .mode_strap_pin_0(pin0), .mode_strap_pin_1(pin1),
    .mode_strap_pin_2(pin2), .ext_access_req(ext_req), .program_counter(pc),
    .program_status_word(psw), .vector_table_base(tbase), .return_address_holder(ret),
    .stack_pointer_view(sp_view), .product_high_word(prod_hi), .product_low_word(prod_lo),
    .irq_accept(irq_accept), .trace_enable(trace_en), .reset_vector_internal(vec_int),
    .ext_bus_16bit(bus16), .strap_mode_invalid(strap_bad), .bus_mode_sel(bus_sel),
    .bus_mode_invalid(bus_bad), .ext_access_grant(grant)
  );

  // ==========
  // Tasks
  // ==========
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Strobes drop at the taking edge, so every access starts on a fresh edge.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, sampled at its closing edge.
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check("reg_rdata", rdata, exp);
  endtask

  // Three edges in reset, exactly what the two-stage strap capture and its latch need.
  task automatic do_reset(input logic [2:0] s);
    @(posedge sys_clk);
    rst   <= 1'b1;
    strap <= s;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic alu(input logic [1:0] op, input logic [31:0] a, b, input logic [3:0] nzvc);
    @(posedge sys_clk);
    alu_valid <= 1'b1;
    alu_op    <= op;
    alu_a     <= a;
    alu_b     <= b;
    @(posedge sys_clk);
    alu_valid <= 1'b0;
    @(posedge sys_clk);
    check("nzvc", psw[3:0], nzvc);
  endtask

  // The request is raised right after the mask write lands, then seen a cycle later.
  task automatic irq(input logic [31:0] p, input logic [4:0] l, input logic e);
    wr(`CPUST_OFS_PSW, p);
    raise <= 1'b1;
    level <= l;
    repeat (2) @(posedge sys_clk);
    check("irq_accept", irq_accept, e);
    raise <= 1'b0;
  endtask

  // ==========
  // Scenarios
  // ==========
  initial
  begin
    for (int s = 0; s < 5; s++)
    begin
      do_reset(s[2:0]);
      @(posedge sys_clk);
      strap <= ~s[2:0];
      repeat (3) @(posedge sys_clk);
      check("vec_int", vec_int, s == 3);
      check("bus16", bus16, s == 1);
      check("strap_bad", strap_bad, s == 2 || s > 3);
    end
    do_reset(3'h3);
    foreach (rv_ofs[i]) rd(rv_ofs[i], rv_val[i]);
    for (int i = 2; i < 8; i++) wr(i[4:0], 32'h1357_9bd0 + i);
    for (int i = 2; i < 8; i++) rd(i[4:0], 32'h1357_9bd0 + i);
    check("tbase", tbase, 32'h1357_9bd2);
    check("ret", ret, 32'h1357_9bd3);
    wr(5'h0b, 32'hffff_ffff);
    rd(5'h0b, 32'h0);
    wr(5'h1e, 32'h2468_ace0);
    rd(5'h1e, 32'h2468_ace0);
    rd(5'h1f, 32'h1357_9bd4);
    check("sp_view", sp_view, 32'h1357_9bd4);
    wr(`CPUST_OFS_PSW, 32'h0000_0020);
    rd(5'h1f, 32'h1357_9bd5);
    check("sp_view", sp_view, 32'h1357_9bd5);
    wr(`CPUST_OFS_PSW, 32'hffff_ffff);
    rd(`CPUST_OFS_PSW, 32'h001f_013f);
    check("trace", trace_en, 1'b1);
    wr(`CPUST_OFS_PSW, 32'h0);
    alu(`CPUST_OP_ADD, 32'h7fff_ffff, 32'h1, 4'ha);
    check("trace", trace_en, 1'b0);
    alu(`CPUST_OP_ADD, 32'hffff_ffff, 32'h1, 4'h5);
    alu(`CPUST_OP_SUB, 32'h0, 32'h1, 4'h9);
    alu(`CPUST_OP_SUB, 32'h5, 32'h5, 4'h4);
    alu(`CPUST_OP_LOGIC, 32'h8000_0000, 32'h0, 4'h8);
    rd(`CPUST_OFS_ALU, 32'h8000_0000);
    @(posedge sys_clk);
    pc_load  <= 1'b1;
    pc_next  <= 32'h000f_1234;
    md_valid <= 1'b1;
    md_high  <= 32'h0a0b_0c0d;
    md_low   <= 32'h0102_0304;
    @(posedge sys_clk);
    pc_load  <= 1'b0;
    md_valid <= 1'b0;
    @(posedge sys_clk);
    check("pc", pc, 32'h000f_1234);
    check("prod_hi", prod_hi, 32'h0a0b_0c0d);
    check("prod_lo", prod_lo, 32'h0102_0304);
    foreach (iq_lvl[i]) irq(iq_psw[i], iq_lvl[i], iq_exp[i]);
    ext_req <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(`CPUST_OFS_BUSMODE, m);
      @(posedge sys_clk);
      check("bus_sel", bus_sel, m);
      check("bus_bad", bus_bad, m == 3);
      check("grant", grant, m == 1);
    end
    wrap_up();
  end

  // The run needs well under a thousand cycles; five thousand leaves ample room.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire

// *** sim/cpust_partner.sv ***
// Board-side model: interrupt request source and mode strap pins.
`timescale 1ns/100ps
`default_nettype none

module cpust_partner
(
  input  wire logic       sys_clk,
  input  wire logic [2:0] strap_code,
  input  wire logic       raise,
  input  wire logic [4:0] level,
  output var  logic       irq_req,
  output var  logic [4:0] irq_level,
  output wire logic       mode_strap_pin_0,
  output wire logic       mode_strap_pin_1,
  output wire logic       mode_strap_pin_2
);
  // Straps are board ties; the bench moves them to pick each mode in reset and to prove they are ignored after it.
  assign mode_strap_pin_0 = strap_code[0];
  assign mode_strap_pin_1 = strap_code[1];
  assign mode_strap_pin_2 = strap_code[2];

  initial
  begin
    irq_req   = 1'b0;
    irq_level = 5'h0;
  end

  // Idle level lines wander so a stale level can never look valid.
  always @(posedge sys_clk)
  begin
    irq_req   <= raise;
    irq_level <= raise ? level : ~irq_level;
  end
endmodule
`default_nettype wire
